// File: shared/tsr_regs.svh
// Register offsets, field positions, reset values and status codes
`ifndef TSR_REGS_SVH
`define TSR_REGS_SVH

`define TSR_OFS_ADDR      2'h0
`define TSR_OFS_CTRL      2'h1
`define TSR_OFS_STAT      2'h2
`define TSR_OFS_DATA      2'h3

`define TSR_CTRL_DONE     7
`define TSR_CTRL_ACK      6
`define TSR_CTRL_STA      5
`define TSR_CTRL_STO      4
`define TSR_CTRL_WCOL     3
`define TSR_CTRL_EN       2
`define TSR_CTRL_IE       0
`define TSR_ADDR_GCE      0

`define TSR_ADDR_RST      8'h00
`define TSR_CTRL_RST      8'h00
`define TSR_DATA_RST      8'hff
`define TSR_STAT_MASK     8'hf8

`define TSR_ST_OWN        8'h60
`define TSR_ST_ARB_OWN    8'h68
`define TSR_ST_GC         8'h70
`define TSR_ST_ARB_GC     8'h78
`define TSR_ST_DATA_ACK   8'h80
`define TSR_ST_DATA_NACK  8'h88
`define TSR_ST_GC_ACK     8'h90
`define TSR_ST_GC_NACK    8'h98
`define TSR_ST_IDLE       8'hf8

`endif

// File: shared/tsr_pkg.sv
// Types shared by the slave receiver
package tsr_pkg;
    typedef enum logic [5:0] {
        S_IDLE     = 6'b000001,
        S_ADDR     = 6'b000010,
        S_ADDR_ACK = 6'b000100,
        S_DATA     = 6'b001000,
        S_DATA_ACK = 6'b010000,
        S_HOLD     = 6'b100000
    } tsr_state_type;
endpackage

// File: core/tsr_sync.sv
// Two-stage synchroniser for one bus pin
`timescale 1ns/1ps
module tsr_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic din,
    output logic      dout
);
    logic meta_reg;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta_reg <= RST_VAL;
            dout     <= RST_VAL;
        end else begin
            meta_reg <= din;
            dout     <= meta_reg;
        end
    end
endmodule

// File: core/tsr_core.sv
// Two-wire slave receiver: bus engine, status codes and register port
// How it works
// [R01] Status reads with the three low bits forced to zero.
// [R02] Own address is the upper seven bits of the own-address register.
// [R03] Address bit 0 enables answering the general call address 0x00.
// [R04] Software enables the unit and acknowledge, with start and stop cleared.
// [R05] Matched address with direction 0 enters receive; direction 1 is not ours.
// [R06] Own write address received sets step-done and a valid status.
// [R07] Address after lost arbitration reports the arbitration-lost codes.
// [R08] Acknowledge enable cleared: next data byte gets a not-acknowledge.
// [R09] Acknowledge enable low: no address answered, bus still watched.
// [R10] In deep sleep a matching address is still answered and wakes the part.
// [R11] After wake, SCL stays low until software clears step-done.
// [R12] Data register need not hold the last bus byte after wake.
// [R13] Status 0x60: own write address received and acknowledged.
// [R14] Status 0x68: arbitration lost, then own write address acknowledged.
// [R15] Status 0x70: general call received and acknowledged.
// [R16] Status 0x78: arbitration lost, then general call acknowledged.
// [R17] Status 0x80: data byte received and acknowledged, read from data.
// [R18] Clearing step-done receives the next byte, ack per acknowledge enable.
// [R19] Status 0x88: data byte received and not acknowledged.
// [R20] After 0x88 clear, not addressed; start request waits for a free bus.
// [R21] SCL is held low while step-done is set.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "tsr_regs.svh"
module tsr_core (
    input  wire logic       SYS_CLK,
    input  wire logic       NRST,
    input  wire logic [1:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic       SCL_IN,
    output logic            SCL_OUT,
    output logic            SCL_OE_N,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N,
    input  wire logic       ARB_LOST,
    input  wire logic       DEEP_SLEEP,
    output logic            WAKE_REQ,
    output logic            START_REQ
);
    logic                 scl_s;
    logic                 sda_s;
    logic                 scl_d_reg;
    logic                 sda_d_reg;
    logic                 scl_rise;
    logic                 scl_fall;
    logic                 bus_start;
    logic                 bus_stop;
    logic [7:0]           addr_reg;
    logic [7:0]           ctrl_reg;
    logic [7:0]           stat_reg;
    logic [7:0]           data_reg;
    logic [7:0]           shift_reg;
    logic [3:0]           bit_cnt_reg;
    tsr_pkg::tsr_state_type state_reg;
    logic                 gc_reg;
    logic                 nack_reg;
    logic                 arb_reg;
    logic                 busy_reg;
    logic                 woke_reg;
    logic                 done_set;
    logic [7:0]           done_code;
    logic                 done_clr;
    logic                 en;
    logic                 ack_en;
    logic                 own_hit;
    logic                 gc_hit;
    logic                 addr_hit;

    tsr_sync u_sync_scl (
        .clk  (SYS_CLK),
        .nrst (NRST),
        .din  (SCL_IN),
        .dout (scl_s)
    );

    tsr_sync u_sync_sda (
        .clk  (SYS_CLK),
        .nrst (NRST),
        .din  (SDA_IN),
        .dout (sda_s)
    );

    // Edge and bus-condition detection on synchronised pins
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_reg;
    assign scl_fall  = ~scl_s & scl_d_reg;
    assign bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
    assign bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

    assign en       = ctrl_reg[`TSR_CTRL_EN];
    assign ack_en   = ctrl_reg[`TSR_CTRL_ACK];
    assign own_hit  = (shift_reg[7:1] == addr_reg[7:1]); // [R02]
    assign gc_hit   = (shift_reg[7:1] == 7'h00) && addr_reg[`TSR_ADDR_GCE]; // [R03]
    // Only a write address with acknowledge enabled is answered
    assign addr_hit = en && ack_en && !shift_reg[0] && (own_hit || gc_hit); // [R05] [R09] [R10]
    assign done_clr = WR && (ADDR == `TSR_OFS_CTRL) && WDATA[`TSR_CTRL_DONE];

    // Status code for the step that just finished
    always_comb begin
        done_set  = 1'b0;
        done_code = `TSR_ST_IDLE;
        if (scl_fall && state_reg == tsr_pkg::S_ADDR_ACK) begin
            done_set = 1'b1;
            if (gc_reg) begin
                done_code = arb_reg ? `TSR_ST_ARB_GC : `TSR_ST_GC; // [R15] [R16]
            end else begin
                done_code = arb_reg ? `TSR_ST_ARB_OWN : `TSR_ST_OWN; // [R13] [R14]
            end
        end else if (scl_fall && state_reg == tsr_pkg::S_DATA_ACK) begin
            done_set = 1'b1;
            if (gc_reg) begin
                done_code = nack_reg ? `TSR_ST_GC_NACK : `TSR_ST_GC_ACK;
            end else begin
                done_code = nack_reg ? `TSR_ST_DATA_NACK : `TSR_ST_DATA_ACK; // [R17] [R19]
            end
        end
    end

    // Byte engine
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            state_reg   <= tsr_pkg::S_IDLE;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 4'h0;
            gc_reg      <= 1'b0;
            nack_reg    <= 1'b0;
        end else if (!en) begin
            state_reg   <= tsr_pkg::S_IDLE;
            bit_cnt_reg <= 4'h0;
        end else begin
            case (state_reg)
                tsr_pkg::S_IDLE: begin
                    if (bus_start) begin
                        state_reg   <= tsr_pkg::S_ADDR;
                        bit_cnt_reg <= 4'h0;
                    end
                end
                tsr_pkg::S_ADDR: begin
                    if (bus_stop) begin
                        state_reg <= tsr_pkg::S_IDLE;
                    end else if (bus_start) begin
                        bit_cnt_reg <= 4'h0;
                    end else if (scl_rise && bit_cnt_reg != 4'h8) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        // Unmatched addresses leave the unit watching the bus
                        if (addr_hit) begin
                            state_reg <= tsr_pkg::S_ADDR_ACK; // [R05]
                            gc_reg    <= gc_hit && !own_hit;
                        end else begin
                            state_reg <= tsr_pkg::S_IDLE; // [R09]
                        end
                    end
                end
                tsr_pkg::S_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_reg <= tsr_pkg::S_HOLD; // [R06]
                        nack_reg  <= 1'b0;
                    end
                end
                tsr_pkg::S_DATA: begin
                    if (bus_stop) begin
                        state_reg <= tsr_pkg::S_IDLE;
                    end else if (bus_start) begin
                        state_reg   <= tsr_pkg::S_ADDR;
                        bit_cnt_reg <= 4'h0;
                    end else if (scl_rise && bit_cnt_reg != 4'h8) begin
                        shift_reg   <= {shift_reg[6:0], sda_s};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == 4'h8) begin
                        state_reg <= tsr_pkg::S_DATA_ACK;
                        nack_reg  <= !ack_en; // [R08] [R18]
                    end
                end
                tsr_pkg::S_DATA_ACK: begin
                    if (scl_fall) begin
                        state_reg <= tsr_pkg::S_HOLD;
                    end
                end
                tsr_pkg::S_HOLD: begin
                    if (done_clr && !WDATA[`TSR_CTRL_STO]) begin
                        bit_cnt_reg <= 4'h0;
                        // After a refused byte the unit drops to not addressed
                        if (nack_reg) begin
                            state_reg <= tsr_pkg::S_IDLE; // [R20]
                        end else begin
                            state_reg <= tsr_pkg::S_DATA; // [R18]
                        end
                    end
                end
                default: begin
                    state_reg <= tsr_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Lost-arbitration marker, consumed by the next address step
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            arb_reg <= 1'b0;
        end else if (ARB_LOST) begin
            arb_reg <= 1'b1; // [R07]
        end else if (done_set && state_reg == tsr_pkg::S_ADDR_ACK) begin
            arb_reg <= 1'b0;
        end else if (bus_stop && state_reg == tsr_pkg::S_IDLE) begin
            arb_reg <= 1'b0;
        end
    end

    // Bus busy between START and STOP
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            busy_reg <= 1'b0;
        end else if (bus_start) begin
            busy_reg <= 1'b1;
        end else if (bus_stop) begin
            busy_reg <= 1'b0;
        end
    end

    // Pin drivers: drive low only during ack and stretch
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            SDA_OUT  <= 1'b0;
            SDA_OE_N <= 1'b1;
            SCL_OUT  <= 1'b0;
            SCL_OE_N <= 1'b1;
        end else begin
            SDA_OUT  <= 1'b0;
            SCL_OUT  <= 1'b0;
            if (state_reg == tsr_pkg::S_ADDR && scl_fall && bit_cnt_reg == 4'h8
                && addr_hit) begin
                SDA_OE_N <= 1'b0;
            end else if (state_reg == tsr_pkg::S_DATA && scl_fall
                         && bit_cnt_reg == 4'h8) begin
                SDA_OE_N <= !ack_en; // [R08] [R18]
            end else if (scl_fall || !en) begin
                SDA_OE_N <= 1'b1;
            end
            if (done_set) begin
                SCL_OE_N <= 1'b0; // [R21] [R11]
            end else if (state_reg == tsr_pkg::S_HOLD && done_clr
                         && !WDATA[`TSR_CTRL_STO]) begin
                SCL_OE_N <= 1'b1; // [R18]
            end else if (!en) begin
                SCL_OE_N <= 1'b1;
            end
        end
    end

    // Wake request held from a sleeping address match until software answers or deep sleep ends
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            woke_reg <= 1'b0;
            WAKE_REQ <= 1'b0;
        end else begin
            if (done_set && state_reg == tsr_pkg::S_ADDR_ACK && DEEP_SLEEP) begin
                woke_reg <= 1'b1; // [R10]
                WAKE_REQ <= 1'b1;
            end else if (done_clr) begin
                woke_reg <= 1'b0; // [R11]
                WAKE_REQ <= 1'b0;
            end else if (!DEEP_SLEEP) begin
                WAKE_REQ <= 1'b0;
            end
        end
    end

    // Pending START to the master side once the bus is free
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            START_REQ <= 1'b0;
        end else begin
            START_REQ <= en && ctrl_reg[`TSR_CTRL_STA] && !busy_reg
                         && state_reg == tsr_pkg::S_IDLE; // [R20]
        end
    end

    // Own address register
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            addr_reg <= `TSR_ADDR_RST;
        end else if (WR && ADDR == `TSR_OFS_ADDR) begin
            addr_reg <= WDATA;
        end
    end

    // Control register: step-done set wins over a clearing write
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            ctrl_reg <= `TSR_CTRL_RST;
        end else begin
            if (WR && ADDR == `TSR_OFS_CTRL) begin
                ctrl_reg[`TSR_CTRL_ACK] <= WDATA[`TSR_CTRL_ACK]; // [R04]
                ctrl_reg[`TSR_CTRL_STA] <= WDATA[`TSR_CTRL_STA];
                ctrl_reg[`TSR_CTRL_STO] <= WDATA[`TSR_CTRL_STO];
                ctrl_reg[`TSR_CTRL_EN]  <= WDATA[`TSR_CTRL_EN];
                ctrl_reg[`TSR_CTRL_IE]  <= WDATA[`TSR_CTRL_IE];
            end
            if (done_set) begin
                ctrl_reg[`TSR_CTRL_DONE] <= 1'b1; // [R06]
            end else if (done_clr) begin
                ctrl_reg[`TSR_CTRL_DONE] <= 1'b0; // [R18]
            end
            if (WR && ADDR == `TSR_OFS_DATA) begin
                ctrl_reg[`TSR_CTRL_WCOL] <= !ctrl_reg[`TSR_CTRL_DONE];
            end
        end
    end

    // Status register
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            stat_reg <= `TSR_ST_IDLE;
        end else if (done_set) begin
            stat_reg <= done_code;
        end else if (done_clr && state_reg == tsr_pkg::S_HOLD) begin
            stat_reg <= `TSR_ST_IDLE;
        end
    end

    // Data register: received bytes, or software writes while step-done is set
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            data_reg <= `TSR_DATA_RST;
        end else if (done_set && state_reg == tsr_pkg::S_DATA_ACK && !woke_reg) begin
            data_reg <= shift_reg; // [R17] [R12]
        end else if (WR && ADDR == `TSR_OFS_DATA && ctrl_reg[`TSR_CTRL_DONE]) begin
            data_reg <= WDATA;
        end
    end

    // Read port: data valid in the cycle after the strobe only
    always_ff @(posedge SYS_CLK) begin
        if (!NRST) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            if (ADDR == `TSR_OFS_ADDR) begin
                RDATA <= addr_reg;
            end else if (ADDR == `TSR_OFS_CTRL) begin
                RDATA <= ctrl_reg;
            end else if (ADDR == `TSR_OFS_STAT) begin
                RDATA <= stat_reg & `TSR_STAT_MASK; // [R01]
            end else begin
                RDATA <= data_reg;
            end
        end else begin
            RDATA <= 8'h00;
        end
    end
endmodule

// File: verif/tsr_core_assertions.sv
// Port-level assertions for the slave receiver
`timescale 1ns/1ps
module tsr_core_checker (
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic [1:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    input wire logic       SCL_IN,
    input wire logic       SCL_OUT,
    input wire logic       SCL_OE_N,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE_N,
    input wire logic       ARB_LOST,
    input wire logic       DEEP_SLEEP,
    input wire logic       WAKE_REQ,
    input wire logic       START_REQ
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!NRST);

    status_mask_a: assert property (RD && ADDR == 2'h2 |=> RDATA[2:0] == 3'h0)
        else $error("status read shows prescaler bits");
    pins_low_a: assert property (!SCL_OUT && !SDA_OUT)
        else $error("bus pin drives a high level");
    wake_cause_a: assert property ($rose(WAKE_REQ) |-> DEEP_SLEEP)
        else $error("wake request outside deep sleep");
    wake_hold_a: assert property (WAKE_REQ && !SCL_OE_N |=> !SCL_OE_N || !WAKE_REQ)
        else $error("clock released while wake pending");
    wake_drop_a: assert property ($fell(WAKE_REQ) |-> !DEEP_SLEEP || $past(WR))
        else $error("wake request dropped without cause");
    sda_change_a: assert property ($changed(SDA_OE_N) |-> !SCL_IN)
        else $error("data line moved while clock high");
    scl_release_a: assert property ($rose(SCL_OE_N) |->
        $past(WR) && $past(ADDR) == 2'h1 && ($past(WDATA) & 8'h90) == 8'h80)
        else $error("clock released without flag clear");
    start_quiet_a: assert property (START_REQ |-> SCL_OE_N && SDA_OE_N)
        else $error("start request while driving the bus");
endmodule

bind tsr_core tsr_core_checker tsr_core_checker_inst (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ARB_LOST(ARB_LOST),
    .DEEP_SLEEP(DEEP_SLEEP), .WAKE_REQ(WAKE_REQ), .START_REQ(START_REQ)
);

// File: verif/tsr_master_model.sv
// Bus master transmitter model, open-drain, 160 ns bit period
`timescale 1ns/1ps
module tsr_master_model (
    input  wire logic clk,
    input  wire logic scl_line,
    input  wire logic sda_line,
    output logic      scl_low,
    output logic      sda_low
);
    int n;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic hold(input int c);
        repeat (c) @(posedge clk);
    endtask

    // Release clock, then wait out up to 3000 cycles of stretching by the slave
    task automatic rise_scl();
        scl_low <= 1'b0;
        for (n = 0; n < 3000 && scl_line !== 1'b1; n++) @(posedge clk);
    endtask

    task automatic start_cond();
        hold(2);
        sda_low <= 1'b1;
        hold(4);
        scl_low <= 1'b1;
    endtask

    // Data changes only in the low phase of the clock
    task automatic put_bit(input logic b, output logic seen);
        hold(3);
        sda_low <= !b;
        hold(2);
        rise_scl();
        hold(2);
        seen = sda_line;
        scl_low <= 1'b1;
    endtask

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) put_bit(d[i], s);
        put_bit(1'b1, s);
        ack = !s;
    endtask

    task automatic stop_cond();
        hold(3);
        sda_low <= 1'b1;
        hold(3);
        rise_scl();
        hold(4);
        sda_low <= 1'b0;
        hold(4);
    endtask
endmodule

// File: verif/tb_tsr_core.sv
// Self-checking bench for the slave receiver
`timescale 1ns/1ps
module tb_tsr_core;
    typedef struct packed {
        logic [7:0] own;
        logic [7:0] abyte;
        logic       arb;
        logic       ack;
        logic [7:0] stat;
    } tsr_row_type;

    logic       SYS_CLK, NRST, WR, RD, ARB_LOST, DEEP_SLEEP;
    logic [1:0] ADDR;
    logic [7:0] WDATA, RDATA, val;
    logic       SCL_OUT, SCL_OE_N, SDA_OUT, SDA_OE_N, WAKE_REQ, START_REQ;
    logic       m_scl_low, m_sda_low, got_ack;
    int         err_total, comparisons, cycles, n;
    wire logic  scl_line = !m_scl_low && SCL_OE_N;
    wire logic  sda_line = !m_sda_low && SDA_OE_N;
    // Own address, address byte, arbitration lost, ack, status
    tsr_row_type rows [8] = '{
        '{8'h54, 8'h54, 1'b0, 1'b1, 8'h60}, '{8'h54, 8'h55, 1'b0, 1'b0, 8'hf8},
        '{8'h54, 8'h56, 1'b0, 1'b0, 8'hf8}, '{8'h55, 8'h00, 1'b0, 1'b1, 8'h70},
        '{8'h54, 8'h00, 1'b0, 1'b0, 8'hf8}, '{8'h54, 8'h54, 1'b1, 1'b1, 8'h68},
        '{8'h55, 8'h00, 1'b1, 1'b1, 8'h78}, '{8'hfe, 8'hfe, 1'b0, 1'b1, 8'h60}};

    tsr_core tsr_core_inst (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .SCL_IN(scl_line), .SCL_OUT(SCL_OUT), .SCL_OE_N(SCL_OE_N),
        .SDA_IN(sda_line), .SDA_OUT(SDA_OUT), .SDA_OE_N(SDA_OE_N), .ARB_LOST(ARB_LOST),
        .DEEP_SLEEP(DEEP_SLEEP), .WAKE_REQ(WAKE_REQ), .START_REQ(START_REQ));
    tsr_master_model tsr_master_model_inst (
        .clk(SYS_CLK), .scl_line(scl_line), .sda_line(sda_line),
        .scl_low(m_scl_low), .sda_low(m_sda_low));

    initial begin
        SYS_CLK = 1'b0;
        forever #10 SYS_CLK = ~SYS_CLK;
    end

    task automatic conclude();
        $display("mismatches %0d of %0d comparisons", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            conclude();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge SYS_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge SYS_CLK);
        WR <= 1'b0;
    endtask

    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge SYS_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge SYS_CLK);
        RD <= 1'b0;
        #1 val = RDATA;
        check(val, exp);
    endtask

    // One byte from the master, optionally opened by a start
    task automatic xfer(input logic st, input logic [7:0] b);
        if (st) tsr_master_model_inst.start_cond();
        tsr_master_model_inst.send_byte(b, got_ack);
        repeat (6) @(posedge SYS_CLK);
    endtask

    task automatic run_row(input tsr_row_type r);
        logic [7:0] base;
        base = r.stat[4] ? 8'h90 : 8'h80;
        reg_wr(2'h0, r.own);
        reg_wr(2'h1, 8'h44);
        if (r.arb) begin
            @(posedge SYS_CLK);
            ARB_LOST <= 1'b1;
            @(posedge SYS_CLK);
            ARB_LOST <= 1'b0;
        end
        xfer(1'b1, r.abyte);
        check({7'h0, got_ack}, {7'h0, r.ack});
        rd_chk(2'h2, r.stat);
        if (r.ack) begin
            check({7'h0, SCL_OE_N}, 8'h00);
            reg_wr(2'h1, 8'hc4);
            xfer(1'b0, r.own ^ 8'h3c);
            check({7'h0, got_ack}, 8'h01);
            rd_chk(2'h2, base);
            rd_chk(2'h3, r.own ^ 8'h3c);
            reg_wr(2'h1, 8'h84);
            xfer(1'b0, 8'h0f);
            check({7'h0, got_ack}, 8'h00);
            rd_chk(2'h2, base + 8'h08);
            reg_wr(2'h1, 8'he4);
        end
        tsr_master_model_inst.stop_cond();
        if (r.ack) begin
            for (n = 0; n < 50 && START_REQ !== 1'b1; n++) @(posedge SYS_CLK);
            check({7'h0, START_REQ}, 8'h01);
        end
    endtask

    initial begin
        NRST = 1'b0;
        WR = 1'b0;
        RD = 1'b0;
        ADDR = 2'h0;
        WDATA = 8'h00;
        ARB_LOST = 1'b0;
        DEEP_SLEEP = 1'b0;
        repeat (16) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        foreach (rows[i]) begin
            run_row(rows[i]);
            $display("row %0d done", i);
        end
        // Acknowledge disabled, then address recognition resumes
        reg_wr(2'h0, 8'h54);
        reg_wr(2'h1, 8'h04);
        xfer(1'b1, 8'h54);
        check({7'h0, got_ack}, 8'h00);
        rd_chk(2'h2, 8'hf8);
        tsr_master_model_inst.stop_cond();
        reg_wr(2'h1, 8'h44);
        xfer(1'b1, 8'h54);
        check({7'h0, got_ack}, 8'h01);
        rd_chk(2'h2, 8'h60);
        reg_wr(2'h1, 8'hc4);
        tsr_master_model_inst.stop_cond();
        $display("ack disable test done");
        // Address match in deep sleep wakes the part and holds the clock
        DEEP_SLEEP <= 1'b1;
        xfer(1'b1, 8'h54);
        check({7'h0, got_ack}, 8'h01);
        check({7'h0, WAKE_REQ}, 8'h01);
        check({7'h0, SCL_OE_N}, 8'h00);
        reg_wr(2'h1, 8'hc4);
        repeat (2) @(posedge SYS_CLK);
        check({7'h0, WAKE_REQ}, 8'h00);
        check({7'h0, SCL_OE_N}, 8'h01);
        DEEP_SLEEP <= 1'b0;
        tsr_master_model_inst.stop_cond();
        $display("wake test done");
        // Data write without step-done is dropped and flags a collision
        reg_wr(2'h3, 8'h5a);
        rd_chk(2'h1, 8'h4c);
        rd_chk(2'h3, 8'h0f);
        // Mid-run reset returns registers to their reset values
        NRST <= 1'b0;
        repeat (16) @(posedge SYS_CLK);
        NRST <= 1'b1;
        repeat (3) @(posedge SYS_CLK);
        rd_chk(2'h0, 8'h00);
        rd_chk(2'h1, 8'h00);
        rd_chk(2'h2, 8'hf8);
        rd_chk(2'h3, 8'hff);
        $display("reset test done");
        conclude();
    end
endmodule
